// ===== hdl/flash_ctl_defines.svh
// Behaviour
// - A program operation only clears bits, new byte is old byte ANDed with the written data.
// - An erase leaves every byte of the affected page at 0xFF.
// - Each write and erase is timed internally and the busy flag is one for its whole duration.
// - During an operation, fetches that need the flash array are stalled until it completes.
// - A cached interrupt may be serviced during an operation when the current code also runs from cache and the core is not halted.
// - Other interrupts are held pending during an operation and released in priority order afterwards.
// - With the write enable bit set, data-move writes program flash, otherwise they go to data RAM.
// - The write enable bit stays set after a flash write until software clears it.
// - Flash is read only by instruction fetches and the code-space move; data-move reads always go to data RAM.
// - A write or erase with the supply monitor disabled causes a flash-error reset instead.
// - Key bytes 0xA5 then 0xF1 must be written, in order and with any delay, before each operation.
// - The flash array is 32 kB or 16 kB depending on variant.
`ifndef FLASH_CTL_DEFINES_SVH
`define FLASH_CTL_DEFINES_SVH
`define KEY_FIRST 8'hA5
`define KEY_SECOND 8'hF1
`define ERASED_BYTE 8'hFF
`define CLK_FREQ_HZ 40000000
`define WRITE_TIME_US 40
`define ERASE_TIME_US 20000
`define WRITE_CYCLES ((`WRITE_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define ERASE_CYCLES ((`ERASE_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define RESERVED_BASE 16'h7C00
`define RESERVED_BYTES 1024
`define PAGE_BYTES 512
`define PROGRAM_STORE_CONTROL_WE_BIT 0
`define PROGRAM_STORE_CONTROL_ERASE_BIT 1
`endif

// ===== hdl/flash_ctl_pkg.sv
package flash_ctl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PROG,
        ST_ERASE
    } fl_state_e;
    typedef enum logic [1:0] {
        KEY_LOCKED,
        KEY_HALF,
        KEY_OPEN,
        KEY_BLOCKED
    } key_state_e;
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] data;
    } xwrite_s;
endpackage

// ===== hdl/flash_write_erase_control.sv
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"
module flash_write_erase_control
    import flash_ctl_pkg::*;
#(
    parameter int ADDR_W = 15,
    parameter int WRITE_CYC = `WRITE_CYCLES,
    parameter int ERASE_CYC = `ERASE_CYCLES,
    parameter bit RESERVE_EN = 1'b1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [1:0] program_store_control_wr,
    input wire logic program_store_control_wr_en,
    input wire logic [7:0] key_wr_data,
    input wire logic key_wr_en,
    input wire xwrite_s xmove_wr,
    input wire logic xmove_rd,
    input wire logic [15:0] xmove_rd_addr,
    input wire logic cmove_rd,
    input wire logic [15:0] cmove_addr,
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    input wire logic fetch_hit,
    input wire logic [7:0] irq_req,
    input wire logic [7:0] irq_cached,
    input wire logic core_halted,
    input wire logic vdd_mon_en,
    output logic flash_busy_flag,
    output logic [1:0] program_store_control,
    output logic [1:0] key_state,
    output logic external_data_ram_wr,
    output logic [15:0] external_data_ram_addr,
    output logic [7:0] external_data_ram_wdata,
    output logic external_data_ram_rd,
    output logic [7:0] cmove_data,
    output logic cmove_valid,
    output logic [7:0] fetch_data,
    output logic fetch_valid,
    output logic fetch_stall,
    output logic [7:0] irq_grant,
    output logic flash_error_reset
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int PG_W = $clog2(`PAGE_BYTES);
    localparam int CNT_W = $clog2(ERASE_CYC + 1);

    logic [7:0] mem [DEPTH];

    fl_state_e st_q, st_d;
    key_state_e key_q, key_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic [PG_W:0] pg_q, pg_d;
    logic [1:0] program_store_control_q, program_store_control_d;
    logic [7:0] pend_q, pend_d;
    logic [7:0] grant_d;
    logic err_d, xwr_d, xrd_d, stall_d, cval_d, fval_d;
    logic [ADDR_W-1:0] pg_base;
    logic in_rsv;
    logic start_op;
    logic [15:0] xaddr_d;
    logic [7:0] xdata_d;
    logic busy_d, irq_cache_ok;
    logic [7:0] irq_all, irq_elig, irq_first;
    logic [8:0] irq_taken;
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [7:0] mem_wdata;

    assign in_rsv = RESERVE_EN && (xmove_wr.addr >= `RESERVED_BASE) &&
        (xmove_wr.addr < (`RESERVED_BASE + 16'(`RESERVED_BYTES)));
    assign start_op = xmove_wr.valid && program_store_control_q[`PROGRAM_STORE_CONTROL_WE_BIT] && (st_q == ST_IDLE);
    assign pg_base = {addr_q[ADDR_W-1:PG_W], {PG_W{1'b0}}};

    // Control register, changed by software only
    always_comb begin
        program_store_control_d = program_store_control_q;
        if (program_store_control_wr_en) begin
            program_store_control_d = program_store_control_wr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            program_store_control_q <= 2'h0;
        end else begin
            program_store_control_q <= program_store_control_d;
        end
    end

    // Key sequence, consumed by every flash attempt
    always_comb begin
        key_d = key_q;
        if (key_wr_en && key_q != KEY_BLOCKED) begin
            if (key_q == KEY_LOCKED && key_wr_data == `KEY_FIRST) begin
                key_d = KEY_HALF;
            end else if (key_q == KEY_HALF && key_wr_data == `KEY_SECOND) begin
                key_d = KEY_OPEN;
            end else begin
                key_d = KEY_BLOCKED;
            end
        end
        if (start_op && key_q == KEY_OPEN) begin
            key_d = KEY_LOCKED;
        end else if (start_op && key_q != KEY_BLOCKED) begin
            key_d = KEY_BLOCKED;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            key_q <= KEY_LOCKED;
        end else begin
            key_q <= key_d;
        end
    end

    // Operation sequencer
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        data_d = data_q;
        err_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (start_op) begin
                    if (!vdd_mon_en) begin
                        err_d = 1'b1;
                    end else if (key_q == KEY_OPEN && !in_rsv) begin
                        addr_d = xmove_wr.addr[ADDR_W-1:0];
                        data_d = xmove_wr.data;
                        if (program_store_control_q[`PROGRAM_STORE_CONTROL_ERASE_BIT]) begin
                            st_d = ST_ERASE;
                            cnt_d = CNT_W'(ERASE_CYC - 1);
                        end else begin
                            st_d = ST_PROG;
                            cnt_d = CNT_W'(WRITE_CYC - 1);
                        end
                    end
                end
            end
            ST_PROG, ST_ERASE: begin
                if (cnt_q == '0) begin
                    st_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            addr_q <= '0;
            data_q <= 8'h00;
            flash_error_reset <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            data_q <= data_d;
            flash_error_reset <= err_d;
        end
    end

    // Erase address walk, one byte of the page per cycle
    always_comb begin
        pg_d = pg_q;
        if (st_q == ST_IDLE) begin
            pg_d = '0;
        end else if (st_q == ST_ERASE && pg_q < (PG_W+1)'(`PAGE_BYTES)) begin
            pg_d = pg_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pg_q <= '0;
        end else begin
            pg_q <= pg_d;
        end
    end

    // Array update: program clears bits at the last busy cycle
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = addr_q;
        mem_wdata = mem[addr_q] & data_q;
        if (st_q == ST_PROG && cnt_q == '0) begin
            mem_we = 1'b1;
        end else if (st_q == ST_ERASE && pg_q < (PG_W+1)'(`PAGE_BYTES)) begin
            mem_we = 1'b1;
            mem_waddr = pg_base | ADDR_W'(pg_q[PG_W-1:0]);
            mem_wdata = `ERASED_BYTE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // Data-move routing to data RAM
    always_comb begin
        xwr_d = xmove_wr.valid && !program_store_control_q[`PROGRAM_STORE_CONTROL_WE_BIT];
        xrd_d = xmove_rd;
        xaddr_d = xmove_rd ? xmove_rd_addr : xmove_wr.addr;
        xdata_d = xmove_wr.data;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            external_data_ram_wr <= 1'b0;
            external_data_ram_addr <= 16'h0000;
            external_data_ram_wdata <= 8'h00;
            external_data_ram_rd <= 1'b0;
        end else begin
            external_data_ram_wr <= xwr_d;
            external_data_ram_addr <= xaddr_d;
            external_data_ram_wdata <= xdata_d;
            external_data_ram_rd <= xrd_d;
        end
    end

    // Fetch and code reads; array misses stall while busy
    always_comb begin
        stall_d = 1'b0;
        fval_d = 1'b0;
        cval_d = 1'b0;
        if (st_q != ST_IDLE) begin
            stall_d = fetch_req && !fetch_hit;
        end else begin
            fval_d = fetch_req;
            cval_d = cmove_rd;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fetch_stall <= 1'b0;
            fetch_valid <= 1'b0;
            cmove_valid <= 1'b0;
        end else begin
            fetch_stall <= stall_d;
            fetch_valid <= fval_d;
            cmove_valid <= cval_d;
        end
    end

    // Interrupt hold, lowest source index first
    assign irq_all = pend_q | irq_req;
    assign irq_cache_ok = fetch_hit && !core_halted;
    assign irq_taken[0] = 1'b0;
    for (genvar i = 0; i < 8; i++) begin : g_irq
        assign irq_elig[i] = (st_q == ST_IDLE) ? irq_all[i] :
            (irq_all[i] && irq_cached[i] && irq_cache_ok);
        assign irq_first[i] = irq_elig[i] && !irq_taken[i];
        assign irq_taken[i+1] = irq_taken[i] || irq_elig[i];
    end

    always_comb begin
        grant_d = irq_first;
        pend_d = irq_all & ~irq_first;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pend_q <= 8'h00;
            irq_grant <= 8'h00;
        end else begin
            pend_q <= pend_d;
            irq_grant <= grant_d;
        end
    end

    // Busy flag follows the next sequencer state
    always_comb begin
        busy_d = (st_d != ST_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flash_busy_flag <= 1'b0;
        end else begin
            flash_busy_flag <= busy_d;
        end
    end

    // Control and key mirrors
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            program_store_control <= 2'h0;
            key_state <= 2'h0;
        end else begin
            program_store_control <= program_store_control_d;
            key_state <= key_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        cmove_data <= mem[cmove_addr[ADDR_W-1:0]];
        fetch_data <= mem[fetch_addr[ADDR_W-1:0]];
    end
endmodule

// ===== test/flash_wec_chk.sv
`timescale 1ns/1ps
module flash_wec_chk
    import flash_ctl_pkg::*;
#(parameter int WRITE_CYC = 8) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire xwrite_s xmove_wr,
    input wire logic xmove_rd,
    input wire logic fetch_req,
    input wire logic fetch_hit,
    input wire logic vdd_mon_en,
    input wire logic program_store_control_wr_en,
    input wire logic flash_busy_flag,
    input wire logic [1:0] program_store_control,
    input wire logic [1:0] key_state,
    input wire logic external_data_ram_wr,
    input wire logic [15:0] external_data_ram_addr,
    input wire logic external_data_ram_rd,
    input wire logic fetch_stall,
    input wire logic flash_error_reset
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire logic go = key_state == 2'h2 && xmove_wr.valid && program_store_control[0];
    property p_start; go && vdd_mon_en && !flash_busy_flag && xmove_wr.addr < 16'h7C00
        |=> flash_busy_flag; endproperty
    a_start: assert property (p_start) else $error("op not started");
    property p_len; $rose(flash_busy_flag) && !program_store_control[1]
        |-> flash_busy_flag [*8] ##1 !flash_busy_flag; endproperty
    a_len: assert property (p_len) else $error("program time wrong");
    property p_err; go && !vdd_mon_en && !flash_busy_flag |=> flash_error_reset; endproperty
    a_err: assert property (p_err) else $error("no error reset");
    property p_relock; $rose(flash_busy_flag) |-> key_state == 2'h0; endproperty
    a_relock: assert property (p_relock) else $error("key not relocked");
    property p_block; key_state == 2'h3 |=> key_state == 2'h3; endproperty
    a_block: assert property (p_block) else $error("block left");
    property p_ram; xmove_wr.valid && !program_store_control[0]
        |=> external_data_ram_wr && external_data_ram_addr == $past(xmove_wr.addr); endproperty
    a_ram: assert property (p_ram) else $error("ram write missing");
    property p_rd; xmove_rd |=> external_data_ram_rd; endproperty
    a_rd: assert property (p_rd) else $error("ram read missing");
    property p_stall; flash_busy_flag && fetch_req && !fetch_hit |=> fetch_stall; endproperty
    a_stall: assert property (p_stall) else $error("fetch not stalled");
    property p_keep; $fell(program_store_control[0]) |-> $past(program_store_control_wr_en); endproperty
    a_keep: assert property (p_keep) else $error("enable dropped");
endmodule
bind flash_write_erase_control flash_wec_chk #(.WRITE_CYC(WRITE_CYC)) i_chk (.*);

// ===== test/core_model.sv
`timescale 1ns/1ps
module core_model
    import flash_ctl_pkg::*;
(
    input wire logic ref_clk,
    output logic [1:0] program_store_control_wr,
    output logic program_store_control_wr_en,
    output logic [7:0] key_wr_data,
    output logic key_wr_en,
    output xwrite_s xmove_wr,
    output logic cmove_rd,
    output logic [15:0] cmove_addr,
    input wire logic [7:0] cmove_data,
    input wire logic cmove_valid
);
    initial {program_store_control_wr, program_store_control_wr_en, key_wr_data, key_wr_en, xmove_wr, cmove_rd, cmove_addr} = '0;
    task automatic ps(input logic [1:0] v);
        @(posedge ref_clk);
        program_store_control_wr <= v;
        program_store_control_wr_en <= 1'b1;
        @(posedge ref_clk);
        program_store_control_wr_en <= 1'b0;
    endtask
    task automatic key(input logic [7:0] k);
        @(posedge ref_clk);
        key_wr_data <= k;
        key_wr_en <= 1'b1;
        @(posedge ref_clk);
        key_wr_en <= 1'b0;
    endtask
    task automatic unlock;
        key(8'hA5);
        key(8'hF1);
    endtask
    // Issued with interrupts quiet, outside the reserved pages
    task automatic xw(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        xmove_wr <= '{1'b1, a, d};
        @(posedge ref_clk);
        xmove_wr <= '{1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        cmove_rd <= 1'b1;
        cmove_addr <= a;
        @(posedge ref_clk);
        cmove_rd <= 1'b0;
        cmove_addr <= ~a;
        @(negedge ref_clk);
        d = cmove_valid ? cmove_data : 8'hXX;
    endtask
endmodule

// ===== test/flash_write_erase_control_tb.sv
`timescale 1ns/1ps
module flash_write_erase_control_tb;
    import flash_ctl_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, xmove_rd = 1'b0, fetch_req = 1'b0, fetch_hit = 1'b0;
    logic vdd_mon_en = 1'b1, core_halted = 1'b0, program_store_control_wr_en, key_wr_en, cmove_rd, g;
    logic [15:0] xmove_rd_addr = 16'h0040, fetch_addr = 16'h0200, cmove_addr;
    logic [7:0] irq_req = 8'h00, irq_cached = 8'h00, key_wr_data, d;
    logic [1:0] program_store_control_wr;
    xwrite_s xmove_wr;
    logic flash_busy_flag, external_data_ram_wr, external_data_ram_rd, cmove_valid, fetch_valid, fetch_stall;
    logic flash_error_reset;
    logic [1:0] program_store_control, key_state;
    logic [15:0] external_data_ram_addr;
    logic [7:0] external_data_ram_wdata, cmove_data, fetch_data, irq_grant;
    int err_total = 0, n_checks = 0, cyc = 0;
    flash_write_erase_control #(.WRITE_CYC(8), .ERASE_CYC(600)) i_dut (.*);
    core_model i_core (.*);
    always #12.5 ref_clk = ~ref_clk;
    task ck(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task wb;
        @(negedge ref_clk);
        for (int i = 0; i < 700 && flash_busy_flag !== 1'b0; i++) @(negedge ref_clk);
        ck(flash_busy_flag === 1'b0, "busy stuck");
    endtask
    task rst;
        @(posedge ref_clk) srst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
    endtask
    task t_flash;
        i_core.ps(2'h3);
        i_core.unlock();
        i_core.xw(16'h0100, 8'h00);
        @(negedge ref_clk);
        ck(flash_busy_flag === 1'b1 && key_state === 2'h0, "erase start");
        wb();
        i_core.rd(16'h01FF, d);
        ck(d === 8'hFF, "erased byte");
        i_core.ps(2'h1);
        i_core.unlock();
        i_core.xw(16'h01FF, 8'h3C);
        wb();
        i_core.unlock();
        i_core.xw(16'h01FF, 8'h0F);
        wb();
        i_core.rd(16'h01FF, d);
        ck(d === 8'h0C && program_store_control[0] === 1'b1, "program value");
        $display("flash test done");
    endtask
    task t_ram;
        @(posedge ref_clk) xmove_rd <= 1'b1;
        xmove_rd_addr <= 16'h0456;
        @(posedge ref_clk) xmove_rd <= 1'b0;
        @(negedge ref_clk);
        ck(external_data_ram_rd === 1'b1 && external_data_ram_addr === 16'h0456 && cmove_valid === 1'b0, "ram read");
        i_core.ps(2'h0);
        i_core.xw(16'h0123, 8'h5A);
        @(negedge ref_clk);
        ck(external_data_ram_wr === 1'b1 && external_data_ram_addr === 16'h0123 && external_data_ram_wdata === 8'h5A, "ram write");
        $display("ram test done");
    endtask
    task t_hold;
        i_core.ps(2'h1);
        i_core.unlock();
        i_core.xw(16'h0200, 8'hFF);
        @(posedge ref_clk) fetch_req <= 1'b1;
        irq_req <= 8'h04;
        @(posedge ref_clk) irq_req <= 8'h00;
        fetch_req <= 1'b0;
        @(negedge ref_clk);
        ck(fetch_stall === 1'b1 && irq_grant === 8'h00, "stall");
        g = 1'b0;
        repeat (12) begin
            @(negedge ref_clk);
            if (irq_grant === 8'h04) g = !flash_busy_flag;
        end
        ck(g, "pending interrupt");
        $display("hold test done");
    endtask
    task t_cache;
        @(posedge ref_clk) fetch_req <= 1'b1;
        fetch_addr <= 16'h01FF;
        @(posedge ref_clk) fetch_req <= 1'b0;
        @(negedge ref_clk);
        ck(fetch_valid === 1'b1 && fetch_data === 8'h0C, "fetch read");
        i_core.unlock();
        i_core.xw(16'h0200, 8'hFF);
        @(posedge ref_clk) fetch_req <= 1'b1;
        fetch_hit <= 1'b1;
        irq_cached <= 8'h02;
        irq_req <= 8'h06;
        @(posedge ref_clk) irq_req <= 8'h00;
        core_halted <= 1'b1;
        irq_cached <= 8'h06;
        @(negedge ref_clk);
        ck(irq_grant === 8'h02 && fetch_stall === 1'b0 && flash_busy_flag === 1'b1, "cached irq");
        ck(fetch_valid === 1'b0, "busy fetch");
        g = 1'b0;
        repeat (12) begin
            @(negedge ref_clk);
            if (irq_grant === 8'h04) g = !flash_busy_flag;
        end
        ck(g, "halted irq held");
        @(posedge ref_clk) fetch_req <= 1'b0;
        fetch_hit <= 1'b0;
        core_halted <= 1'b0;
        $display("cache test done");
    endtask
    task t_fault;
        @(posedge ref_clk) vdd_mon_en <= 1'b0;
        i_core.unlock();
        i_core.xw(16'h0300, 8'h00);
        @(negedge ref_clk);
        ck(flash_error_reset === 1'b1 && flash_busy_flag === 1'b0, "monitor off");
        @(posedge ref_clk) vdd_mon_en <= 1'b1;
        i_core.key(8'hF1);
        i_core.unlock();
        i_core.xw(16'h0300, 8'h00);
        @(negedge ref_clk);
        ck(flash_busy_flag === 1'b0 && key_state === 2'h3, "bad key");
        rst();
        @(negedge ref_clk);
        ck(key_state === 2'h0, "reset unlock");
        $display("fault test done");
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        rst();
        t_flash();
        t_ram();
        t_hold();
        t_cache();
        t_fault();
        close_out();
    end
endmodule
